/* rtl/pagpio_top.sv */
// Port A general purpose I/O with keyboard input gating and converter overrides
`timescale 1ns/1ns
`include "pagpio_defs.svh"
module pagpio_top
  import pagpio_pkg::*;
#(
  parameter int PORT_W = `PAG_PORT_W
)
(
  input  wire logic                   mclk_in,
  input  wire logic                   reset_n_in,
  input  wire logic [`PAG_ADDR_W-1:0] addr_in,
  input  wire logic                   wr_en_in,
  input  wire logic                   rd_en_in,
  input  wire logic [7:0]             wdata_in,
  output logic      [7:0]             rdata_out,
  input  wire logic [PORT_W-1:0]      pin_in,
  output logic      [PORT_W-1:0]      pin_out,
  output logic      [PORT_W-1:0]      pin_oe_out,
  output logic      [PORT_W-1:0]      pin_pullup_out,
  output logic      [PORT_W-1:0]      pin_analog_out,
  input  wire logic [PORT_W-1:0]      kbd_irq_enable_bits_in,
  output logic      [PORT_W-1:0]      kbd_inputs_out,
  input  wire logic                   adc_enable_in,
  input  wire logic [`PAG_CH_W-1:0]   converter_channel_select_in,
  output logic      [7:0]             port_f_dir_out,
  output logic      [7:0]             port_g_dir_out
);

  pag_byte_t         port_a_latch_ff;
  pag_byte_t         port_a_dir_ff;
  pag_byte_t         port_a_pullup_en_ff;
  pag_byte_t         port_f_dir_ff;
  pag_byte_t         port_g_dir_ff;
  logic [PORT_W-1:0] pin_meta_ff;
  logic [PORT_W-1:0] pin_sync_ff;
  logic [PORT_W-1:0] analog_sel;
  logic [PORT_W-1:0] oe_eff;
  pag_byte_t         nxt_rdata;
  logic              wr_a_latch;
  logic              wr_a_dir;
  logic              wr_a_pullup;
  logic              wr_f_dir;
  logic              wr_g_dir;

  function automatic logic hit(input logic [`PAG_ADDR_W-1:0] a, input logic [`PAG_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // Write strobe decode, unmapped writes ignored
  always_comb
  begin
    wr_a_latch  = 1'b0;
    wr_a_dir    = 1'b0;
    wr_a_pullup = 1'b0;
    wr_f_dir    = 1'b0;
    wr_g_dir    = 1'b0;
    if (wr_en_in)
    begin
      if (hit(addr_in, `PAG_OFS_A_LATCH))
      begin
        wr_a_latch = 1'b1;
      end
      else if (hit(addr_in, `PAG_OFS_A_DIR))
      begin
        wr_a_dir = 1'b1;
      end
      else if (hit(addr_in, `PAG_OFS_A_PULLUP))
      begin
        wr_a_pullup = 1'b1;
      end
      else if (hit(addr_in, `PAG_OFS_F_DIR))
      begin
        wr_f_dir = 1'b1;
      end
      else if (hit(addr_in, `PAG_OFS_G_DIR))
      begin
        wr_g_dir = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (wr_a_latch)
    begin
      port_a_latch_ff <= wdata_in;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      port_a_dir_ff <= `PAG_DIR_RST;
    end
    else if (wr_a_dir)
    begin
      port_a_dir_ff <= wdata_in;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      port_a_pullup_en_ff <= `PAG_PULLUP_RST;
    end
    else if (wr_a_pullup)
    begin
      port_a_pullup_en_ff <= wdata_in;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      port_f_dir_ff <= `PAG_DIR_RST;
    end
    else if (wr_f_dir)
    begin
      port_f_dir_ff <= wdata_in;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      port_g_dir_ff <= `PAG_DIR_RST;
    end
    else if (wr_g_dir)
    begin
      port_g_dir_ff <= wdata_in;
    end
  end

  // Pin synchroniser
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end
    else
    begin
      pin_meta_ff <= pin_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  always_comb
  begin
    analog_sel = '0;
    for (int i = 0; i < PORT_W; i++)
    begin
      if (adc_enable_in && (converter_channel_select_in == (`PAG_CH_BASE + 5'(i))))
      begin
        analog_sel[i] = 1'b1;
      end
    end
  end

  assign oe_eff = port_a_dir_ff[PORT_W-1:0] & ~analog_sel;

  // Read mux, unmapped reads zero
  always_comb
  begin
    nxt_rdata = 8'h00;
    if (hit(addr_in, `PAG_OFS_A_LATCH))
    begin
      nxt_rdata = (port_a_latch_ff & port_a_dir_ff) | (pin_sync_ff & ~port_a_dir_ff);
    end
    else if (hit(addr_in, `PAG_OFS_A_DIR))
    begin
      nxt_rdata = port_a_dir_ff;
    end
    else if (hit(addr_in, `PAG_OFS_A_PULLUP))
    begin
      nxt_rdata = port_a_pullup_en_ff;
    end
    else if (hit(addr_in, `PAG_OFS_F_DIR))
    begin
      nxt_rdata = port_f_dir_ff;
    end
    else if (hit(addr_in, `PAG_OFS_G_DIR))
    begin
      nxt_rdata = port_g_dir_ff;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rdata_out <= 8'h00;
    end
    else if (rd_en_in)
    begin
      rdata_out <= nxt_rdata;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pin_out    <= '0;
      pin_oe_out <= '0;
    end
    else
    begin
      pin_out    <= port_a_latch_ff[PORT_W-1:0] & oe_eff;
      pin_oe_out <= oe_eff;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pin_pullup_out <= '0;
    end
    else
    begin
      pin_pullup_out <= port_a_pullup_en_ff[PORT_W-1:0] & ~port_a_dir_ff[PORT_W-1:0] & ~analog_sel;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pin_analog_out <= '0;
    end
    else
    begin
      pin_analog_out <= analog_sel;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      kbd_inputs_out <= '0;
    end
    else
    begin
      kbd_inputs_out <= pin_sync_ff & kbd_irq_enable_bits_in;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      port_f_dir_out <= 8'h00;
    end
    else
    begin
      port_f_dir_out <= port_f_dir_ff;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      port_g_dir_out <= 8'h00;
    end
    else
    begin
      port_g_dir_out <= port_g_dir_ff;
    end
  end

endmodule

/* rtl/pagpio_defs.svh */
// Register offsets, widths and reset values for the port A block
`ifndef PAGPIO_DEFS_SVH
`define PAGPIO_DEFS_SVH
`define PAG_ADDR_W          16
`define PAG_PORT_W          8
`define PAG_OFS_A_LATCH     16'h0000
`define PAG_OFS_A_DIR       16'h0004
`define PAG_OFS_A_PULLUP    16'h000D
`define PAG_OFS_F_DIR       16'h0444
`define PAG_OFS_G_DIR       16'h0445
`define PAG_DIR_RST         8'h00
`define PAG_PULLUP_RST      8'h00
`define PAG_CH_W            5
`define PAG_CH_BASE         5'h08
`endif

/* rtl/pagpio_pkg.sv */
// Types shared by the port A block
package pagpio_pkg;
  typedef logic [7:0] pag_byte_t;
endpackage

/* tb/pag_monitor.sv */
// Checker for the port A block
`timescale 1ns/1ns
module pag_monitor
(
  input wire logic        mclk_in,
  input wire logic        reset_n_in,
  input wire logic        wr_en_in,
  input wire logic        rd_en_in,
  input wire logic        adc_enable_in,
  input wire logic [15:0] addr_in,
  input wire logic [4:0]  converter_channel_select_in,
  input wire logic [7:0]  wdata_in,
  input wire logic [7:0]  rdata_out,
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  pin_oe_out,
  input wire logic [7:0]  pin_pullup_out,
  input wire logic [7:0]  pin_analog_out,
  input wire logic [7:0]  kbd_irq_enable_bits_in,
  input wire logic [7:0]  kbd_inputs_out,
  input wire logic [7:0]  port_f_dir_out,
  input wire logic [7:0]  port_g_dir_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  sequence s_fwr; wr_en_in && addr_in == 16'h0444; endsequence
  sequence s_gwr; wr_en_in && addr_in == 16'h0445; endsequence
  sequence s_unm; rd_en_in && !(addr_in inside {16'h0000, 16'h0004, 16'h000D, 16'h0444, 16'h0445}); endsequence
  // Register stage then output stage: two edges
  AST_FDIR: assert property (s_fwr |-> ##2 port_f_dir_out == $past(wdata_in, 2)) else $error("f dir");
  AST_GDIR: assert property (s_gwr |-> ##2 port_g_dir_out == $past(wdata_in, 2)) else $error("g dir");
  AST_ANOE: assert property ((pin_oe_out & pin_analog_out) == 8'h00) else $error("analog oe");
  AST_PUOE: assert property ((pin_pullup_out & pin_oe_out) == 8'h00) else $error("pullup oe");
  AST_DRV: assert property ((pin_out & ~pin_oe_out) == 8'h00) else $error("drive");
  AST_CH: assert property (adc_enable_in && converter_channel_select_in[4:3] == 2'b01 |=>
    pin_analog_out == 8'h01 << ($past(converter_channel_select_in) - 5'h08)) else $error("channel");
  AST_DIG: assert property (!adc_enable_in |=> pin_analog_out == 8'h00) else $error("digital");
  AST_KBD: assert property ((kbd_inputs_out & ~$past(kbd_irq_enable_bits_in)) == 8'h00) else $error("kbd");
  AST_UNM: assert property (s_unm |=> rdata_out == 8'h00) else $error("unm");
  AST_HOLD: assert property (!rd_en_in |=> $stable(rdata_out)) else $error("rdata hold");
endmodule
bind pagpio_top pag_monitor i_mon (.*);

/* tb/pag_board.sv */
// Board model around the port A pins
`timescale 1ns/1ns
module pag_board
(
  input  wire logic       mclk_in,
  input  wire logic [7:0] drv_in,
  input  wire logic [7:0] oe_in,
  input  wire logic [7:0] pu_in,
  input  wire logic [7:0] ext_in,
  input  wire logic [7:0] ext_en_in,
  output logic      [7:0] pin_lvl_out
);
  logic [7:0] float_ff = 8'h55;
  always_ff @(posedge mclk_in) float_ff <= ~float_ff;
  assign pin_lvl_out = oe_in & drv_in | ~oe_in & (ext_en_in & ext_in | ~ext_en_in & (pu_in | float_ff));
endmodule

/* tb/pagpio_top_tb.sv */
// Testbench for the port A block
`timescale 1ns/1ns
module pagpio_top_tb;
  logic        mclk_in = 0, reset_n_in = 0, wr_en_in = 0, rd_en_in = 0, adc_enable_in = 0;
  logic [15:0] addr_in = 16'h0000;
  logic [4:0]  converter_channel_select_in = 5'h00;
  logic [7:0]  wdata_in = 8'h00, kbd_irq_enable_bits_in = 8'h00, ext = 8'h3C, ext_en = 8'hFF;
  logic [7:0]  rdata_out, pin_in, pin_out, pin_oe_out, pin_pullup_out, pin_analog_out;
  logic [7:0]  kbd_inputs_out, port_f_dir_out, port_g_dir_out;
  int          miscompares = 0, compares = 0, i;
  pagpio_top i_dut (.*);
  pag_board i_board (.mclk_in(mclk_in), .drv_in(pin_out), .oe_in(pin_oe_out), .pu_in(pin_pullup_out),
    .ext_in(ext), .ext_en_in(ext_en), .pin_lvl_out(pin_in));
  initial forever #25 mclk_in = ~mclk_in;
  task chk(string n, logic [7:0] s, logic [7:0] e);
    compares++;
    if (s !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(logic [15:0] a, logic [7:0] d);
    @(posedge mclk_in) {addr_in, wdata_in, wr_en_in} <= {a, d, 1'b1};
    @(posedge mclk_in) wr_en_in <= 0;
  endtask
  task rd(logic [15:0] a, logic [7:0] e);
    @(posedge mclk_in) {addr_in, rd_en_in} <= {a, 1'b1};
    @(posedge mclk_in) rd_en_in <= 0;
    #1 chk("rdata", rdata_out, e);
  endtask
  task wt(int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task give_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge mclk_in);
    miscompares++;
    give_verdict;
  end
  initial
  begin
    repeat (3) @(posedge mclk_in);
    reset_n_in <= 1;
    rd(16'h0004, 8'h00);
    rd(16'h0444, 8'h00);
    rd(16'h0445, 8'h00);
    $display("test reset done");
    wr(16'h0000, 8'hA5);
    wr(16'h0004, 8'h0F);
    wt(3);
    chk("oe", pin_oe_out, 8'h0F);
    chk("drive", pin_out, 8'h05);
    rd(16'h0000, 8'h35);
    $display("test dir done");
    @(posedge mclk_in) ext_en <= 8'h00;
    wr(16'h000D, 8'hFF);
    wt(4);
    chk("pullup", pin_pullup_out, 8'hF0);
    rd(16'h0000, 8'hF5);
    wr(16'h000D, 8'h3C);
    wt(3);
    chk("pullup", pin_pullup_out, 8'h30);
    $display("test pullup done");
    wr(16'h0444, 8'h5A);
    wr(16'h0445, 8'hA5);
    rd(16'h0444, 8'h5A);
    rd(16'h0445, 8'hA5);
    chk("fdir", port_f_dir_out, 8'h5A);
    chk("gdir", port_g_dir_out, 8'hA5);
    rd(16'h0100, 8'h00);
    $display("test regs done");
    @(posedge mclk_in) adc_enable_in <= 1;
    for (i = 8; i < 16; i++)
    begin
      @(posedge mclk_in) converter_channel_select_in <= i[4:0];
      wt(2);
      chk("analog", pin_analog_out, 8'h01 << (i - 8));
      chk("aoe", pin_oe_out, 8'h0F & ~(8'h01 << (i - 8)));
      chk("apu", pin_pullup_out, 8'h30 & ~(8'h01 << (i - 8)));
    end
    @(posedge mclk_in) converter_channel_select_in <= 5'h10;
    wt(2);
    chk("analog", pin_analog_out, 8'h00);
    @(posedge mclk_in) adc_enable_in <= 0;
    wt(2);
    chk("analog", pin_analog_out, 8'h00);
    $display("test analog done");
    @(posedge mclk_in) kbd_irq_enable_bits_in <= 8'h3C;
    wt(4);
    chk("kbd", kbd_inputs_out, 8'h34);
    wr(16'h0004, 8'h00);
    wt(3);
    chk("pullup", pin_pullup_out, 8'h3C);
    $display("test kbd done");
    @(posedge mclk_in) reset_n_in <= 0;
    wt(2);
    chk("oe", pin_oe_out, 8'h00);
    @(posedge mclk_in) reset_n_in <= 1;
    wr(16'h0004, 8'hFF);
    rd(16'h0000, 8'hA5);
    chk("drive", pin_out, 8'hA5);
    $display("test latch done");
    give_verdict;
  end
endmodule
